/* File: design/mdpa_top.sv */
// Summary of operation
// RL1 - Start at address zero, loop follows measurement.
// RL2 - Nonzero address enables multidrop; limit 15 or 63.
// RL3 - Multidrop parks loop output at 4 mA.
// RL4 - Multidrop suppresses the alarm current level.
// RL5 - Multidrop reports failures only as digital status.
// RL6 - Answer commands only carrying own address.
// RL7 - Host gives each transmitter a unique address.
// RL8 - Analog output follows the selected primary variable.
// RL9 - Out-of-range address is refused, old kept.
`timescale 1ns/1ns
`default_nettype none
module mdpa_top
    import mdpa_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              clk_en,
    input  wire logic              rev7_mode,
    input  wire logic              addr_wr_valid,
    input  wire logic [ADDR_W-1:0] addr_wr_data,
    output logic                   addr_wr_ack,
    output logic                   addr_wr_nak,
    output logic [ADDR_W-1:0]      poll_addr,
    output logic                   multidrop,
    input  wire logic              cmd_valid,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    output logic                   cmd_accept,
    input  wire mdpa_pv_src_t      primary_variable_src,
    input  wire logic [CODE_W-1:0] pressure_code,
    input  wire logic [CODE_W-1:0] scaled_code,
    input  wire logic              fail_detect,
    input  wire logic              alarm_upscale_pin,
    input  wire logic              fail_status_clr,
    output logic                   fail_status,
    output logic                   alarm_current,
    output logic [CODE_W-1:0]      loop_code
);
    mdpa_state_t       st_r;
    mdpa_state_t       st_nxt;
    logic [CODE_W-1:0] pv_code;
    logic              md_now;

    mdpa_match_if m ();

    assign m.poll_addr = st_r.poll_addr;
    assign m.rev7      = rev7_mode;
    assign m.wr_addr   = addr_wr_data;
    assign m.cmd_addr  = cmd_addr;

    mdpa_addr_check u_check (
        .m (m.chk)
    );

    always_comb begin
        st_nxt = st_r;
        md_now = (st_r.poll_addr != POLL_ADDR_RST); // RL2
        pv_code = (primary_variable_src == MDPA_PV_SCALED) ? scaled_code
                                                           : pressure_code; // RL8
        if (clk_en) begin
            st_nxt.sw_meta    = alarm_upscale_pin;
            st_nxt.sw_sync    = st_r.sw_meta;
            st_nxt.wr_ack     = 1'b0;
            st_nxt.wr_nak     = 1'b0;
            st_nxt.cmd_accept = cmd_valid && m.cmd_hit; // RL6
            if (addr_wr_valid) begin
                if (m.wr_ok) begin
                    st_nxt.poll_addr = addr_wr_data; // RL2
                    st_nxt.wr_ack    = 1'b1;
                end else begin
                    st_nxt.wr_nak = 1'b1; // RL9
                end
            end
            // A failure in the same cycle as the clear keeps the flag set.
            if (fail_status_clr) begin
                st_nxt.fail_status = 1'b0;
            end
            if (fail_detect) begin
                st_nxt.fail_status = 1'b1; // RL5
            end
            if (md_now) begin
                st_nxt.loop_code = LOOP_4MA_CODE; // RL3
                st_nxt.alarm_on  = 1'b0; // RL4
            end else if (fail_detect) begin
                st_nxt.loop_code = st_r.sw_sync ? LOOP_ALARM_HI : LOOP_ALARM_LO;
                st_nxt.alarm_on  = 1'b1;
            end else begin
                st_nxt.loop_code = pv_code; // RL1
                st_nxt.alarm_on  = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r.poll_addr   <= POLL_ADDR_RST; // RL1
            st_r.wr_ack      <= 1'b0;
            st_r.wr_nak      <= 1'b0;
            st_r.cmd_accept  <= 1'b0;
            st_r.loop_code   <= LOOP_4MA_CODE;
            st_r.alarm_on    <= 1'b0;
            st_r.fail_status <= 1'b0;
            st_r.sw_meta     <= 1'b0;
            st_r.sw_sync     <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign addr_wr_ack   = st_r.wr_ack;
    assign addr_wr_nak   = st_r.wr_nak;
    assign poll_addr     = st_r.poll_addr;
    assign multidrop     = md_now;
    assign cmd_accept    = st_r.cmd_accept;
    assign fail_status   = st_r.fail_status;
    assign alarm_current = st_r.alarm_on;
    assign loop_code     = st_r.loop_code;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence wr_legal_nz_s;
        clk_en && addr_wr_valid && m.wr_ok && (addr_wr_data != POLL_ADDR_RST);
    endsequence

    sequence next_en_s;
        ##1 clk_en;
    endsequence

    addr_accept_a: assert property (clk_en && addr_wr_valid && m.wr_ok |=> // RL2
        addr_wr_ack && !addr_wr_nak && poll_addr == $past(addr_wr_data))
        else $error("legal poll address not taken");

    addr_reject_a: assert property (clk_en && addr_wr_valid && !m.wr_ok |=> // RL9
        addr_wr_nak && !addr_wr_ack && poll_addr == $past(poll_addr))
        else $error("illegal poll address changed state");

    md_entry_a: assert property (wr_legal_nz_s ##0 next_en_s |=> // RL3
        multidrop && loop_code == LOOP_4MA_CODE)
        else $error("multidrop entry did not park loop");

    md_park_a: assert property (clk_en && multidrop |=> // RL3
        loop_code == LOOP_4MA_CODE)
        else $error("loop not held at 4 mA in multidrop");

    md_no_alarm_a: assert property (clk_en && multidrop && fail_detect |=> // RL4
        !alarm_current && loop_code != LOOP_ALARM_HI && loop_code != LOOP_ALARM_LO)
        else $error("alarm current driven in multidrop");

    md_fail_msg_a: assert property (clk_en && fail_detect |=> // RL5
        fail_status)
        else $error("failure not flagged in digital status");

    cmd_match_a: assert property (clk_en && cmd_valid |=> // RL6
        cmd_accept == ($past(cmd_addr) == $past(poll_addr)))
        else $error("command address filter wrong");

    // Reset is released on a clock edge, so the sampled reset gates that first attempt.
    p2p_pv_a: assert property (!rst && clk_en && !multidrop && !fail_detect |=> // RL8
        loop_code == ($past(primary_variable_src) == MDPA_PV_SCALED ?
                      $past(scaled_code) : $past(pressure_code)) && !alarm_current)
        else $error("loop does not follow primary variable");

    p2p_zero_a: assert property (poll_addr == POLL_ADDR_RST |-> !multidrop) // RL1
        else $error("address zero not point to point");

    freeze_a: assert property (!clk_en |=> $stable(st_r))
        else $error("state moved with clock enable low");

    // The range checks below use the package limits, not the checker's verdict.
    sequence wr_req_s;
        clk_en && addr_wr_valid;
    endsequence

    sequence p2p_fail_s;
        clk_en && !multidrop && fail_detect;
    endsequence

    wr_excl_a: assert property (!(addr_wr_ack && addr_wr_nak)) // RL9
        else $error("address write both taken and refused");

    wr_quiet_a: assert property (clk_en && !addr_wr_valid |=> // RL9
        !addr_wr_ack && !addr_wr_nak)
        else $error("address answer without a request");

    addr_hold_a: assert property (clk_en && !addr_wr_valid |=> // RL9
        poll_addr == $past(poll_addr))
        else $error("poll address moved without a write");

    rev5_cap_a: assert property (wr_req_s ##0 (!rev7_mode && addr_wr_data > POLL_MAX_REV5) // RL2
        |=> addr_wr_nak && !addr_wr_ack && poll_addr == $past(poll_addr))
        else $error("revision 5 address limit not enforced");

    rev7_full_a: assert property (wr_req_s ##0 rev7_mode |=> // RL2
        addr_wr_ack && poll_addr == $past(addr_wr_data))
        else $error("revision 7 address not taken");

    md_nonzero_a: assert property (poll_addr != POLL_ADDR_RST |-> multidrop) // RL2
        else $error("nonzero address not multidrop");

    cmd_idle_a: assert property (clk_en && !cmd_valid |=> !cmd_accept) // RL6
        else $error("command accepted without a request");

    alarm_hi_a: assert property (p2p_fail_s ##0 st_r.sw_sync |=> // RL4
        alarm_current && loop_code == LOOP_ALARM_HI)
        else $error("upscale alarm level wrong");

    alarm_lo_a: assert property (p2p_fail_s ##0 !st_r.sw_sync |=> // RL4
        alarm_current && loop_code == LOOP_ALARM_LO)
        else $error("downscale alarm level wrong");

    fail_clr_a: assert property (clk_en && fail_status_clr && !fail_detect |=> // RL5
        !fail_status)
        else $error("failure status not cleared");

    fail_hold_a: assert property (clk_en && !fail_status_clr && fail_status |=> // RL5
        fail_status)
        else $error("failure status dropped without a clear");

    sw_sync_a: assert property (clk_en |=> st_r.sw_sync == $past(st_r.sw_meta)) // RL4
        else $error("alarm switch synchroniser skipped a stage");
endmodule
`default_nettype wire

/* File: design/mdpa_pkg.sv */
package mdpa_pkg;

    localparam int unsigned ADDR_W = 6;
    localparam int unsigned CODE_W = 16;

    localparam logic [ADDR_W-1:0] POLL_ADDR_RST = 6'h00;
    localparam logic [ADDR_W-1:0] POLL_MAX_REV5 = 6'h0F;
    localparam logic [ADDR_W-1:0] POLL_MAX_REV7 = 6'h3F;

    // Loop DAC codes, full scale 0 mA to 25 mA.
    localparam logic [CODE_W-1:0] LOOP_4MA_CODE   = 16'h28F6;
    localparam logic [CODE_W-1:0] LOOP_ALARM_HI   = 16'hD70A;
    localparam logic [CODE_W-1:0] LOOP_ALARM_LO   = 16'h2452;

    typedef enum logic {
        MDPA_PV_PRESSURE,
        MDPA_PV_SCALED
    } mdpa_pv_src_t;

    typedef struct packed {
        logic [ADDR_W-1:0] poll_addr;
        logic              wr_ack;
        logic              wr_nak;
        logic              cmd_accept;
        logic [CODE_W-1:0] loop_code;
        logic              alarm_on;
        logic              fail_status;
        logic              sw_meta;
        logic              sw_sync;
    } mdpa_state_t;

endpackage

/* File: design/mdpa_match_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface mdpa_match_if;
    import mdpa_pkg::*;
    logic [ADDR_W-1:0] poll_addr;
    logic              rev7;
    logic [ADDR_W-1:0] wr_addr;
    logic [ADDR_W-1:0] cmd_addr;
    logic              wr_ok;
    logic              cmd_hit;

    modport ctrl (
        output poll_addr,
        output rev7,
        output wr_addr,
        output cmd_addr,
        input  wr_ok,
        input  cmd_hit
    );

    modport chk (
        input  poll_addr,
        input  rev7,
        input  wr_addr,
        input  cmd_addr,
        output wr_ok,
        output cmd_hit
    );
endinterface
`default_nettype wire

/* File: design/mdpa_addr_check.sv */
`timescale 1ns/1ns
`default_nettype none
module mdpa_addr_check
    import mdpa_pkg::*;
(
    mdpa_match_if.chk m
);
    logic [ADDR_W-1:0] limit;

    // Zero is always legal so that a multidrop unit can return to analog service.
    always_comb begin
        limit = m.rev7 ? POLL_MAX_REV7 : POLL_MAX_REV5; // RL2
        m.wr_ok = (m.wr_addr <= limit); // RL9
        m.cmd_hit = (m.cmd_addr == m.poll_addr); // RL6
    end
endmodule
`default_nettype wire

/* File: tb/mdpa_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module mdpa_host_model
    import mdpa_pkg::*;
(
    input  wire logic              clock,
    output logic                   addr_wr_valid,
    output logic [ADDR_W-1:0]      addr_wr_data,
    output logic                   cmd_valid,
    output logic [ADDR_W-1:0]      cmd_addr
);
    initial begin
        addr_wr_valid = 1'b0;
        addr_wr_data = 6'h2A;
        cmd_valid = 1'b0;
        cmd_addr = 6'h15;
    end

    // One device on this line, so every address given is unique.
    task automatic set_addr(input logic [ADDR_W-1:0] a);
        @(posedge clock);
        addr_wr_valid <= 1'b1;
        addr_wr_data <= a;
        @(posedge clock);
        addr_wr_valid <= 1'b0;
        addr_wr_data <= ~a;
    endtask

    task automatic send_cmd(input logic [ADDR_W-1:0] a);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_addr <= a;
        @(posedge clock);
        cmd_valid <= 1'b0;
        cmd_addr <= ~a;
    endtask
endmodule
`default_nettype wire

/* File: tb/mdpa_top_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module mdpa_top_tb_top
    import mdpa_pkg::*;
;
    logic clock = 1'b0, rst = 1'b1, clk_en = 1'b1, rev7_mode = 1'b0;
    logic fail_detect = 1'b0, alarm_upscale_pin = 1'b1, fail_status_clr = 1'b0;
    mdpa_pv_src_t primary_variable_src = MDPA_PV_PRESSURE;
    logic [CODE_W-1:0] pressure_code = 16'h1234, scaled_code = 16'h5678, loop_code;
    wire logic addr_wr_valid, cmd_valid;
    wire logic [ADDR_W-1:0] addr_wr_data, cmd_addr;
    logic addr_wr_ack, addr_wr_nak, multidrop, cmd_accept, fail_status, alarm_current;
    logic [ADDR_W-1:0] poll_addr;
    int error_cnt = 0, checks = 0;

    always #5 clock = ~clock;

    mdpa_host_model u_host (.clock, .addr_wr_valid, .addr_wr_data, .cmd_valid, .cmd_addr);
    mdpa_top u_dut (.clock, .rst, .clk_en, .rev7_mode, .addr_wr_valid, .addr_wr_data,
        .addr_wr_ack, .addr_wr_nak, .poll_addr, .multidrop, .cmd_valid, .cmd_addr,
        .cmd_accept, .primary_variable_src, .pressure_code, .scaled_code, .fail_detect,
        .alarm_upscale_pin, .fail_status_clr, .fail_status, .alarm_current, .loop_code);

    task automatic close_out;
        if (error_cnt == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [CODE_W-1:0] got, input logic [CODE_W-1:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic ok);
        u_host.set_addr(a);
        #1;
        chk(addr_wr_ack, ok);
        chk(addr_wr_nak, !ok);
    endtask

    task automatic t_p2p;
        step(2);
        chk(loop_code, 16'h1234);
        @(posedge clock);
        primary_variable_src <= MDPA_PV_SCALED;
        step(1);
        chk(loop_code, 16'h5678);
        chk(multidrop, 1'b0);
    endtask

    task automatic t_range;
        wr(6'h10, 1'b0);
        chk(poll_addr, 6'h00);
        wr(6'h0F, 1'b1);
        chk(multidrop, 1'b1);
        @(posedge clock);
        rev7_mode <= 1'b1;
        wr(6'h3F, 1'b1);
        @(posedge clock);
        clk_en <= 1'b0;
        u_host.set_addr(6'h01);
        #1;
        chk({addr_wr_ack, addr_wr_nak, poll_addr}, 8'h3F);
        @(posedge clock);
        clk_en <= 1'b1;
        rev7_mode <= 1'b0;
        wr(6'h00, 1'b1);
    endtask

    task automatic t_multi;
        wr(6'h05, 1'b1);
        @(posedge clock);
        fail_detect <= 1'b1;
        step(1);
        chk(loop_code, LOOP_4MA_CODE);
        chk(alarm_current, 1'b0);
        chk(fail_status, 1'b1);
        wr(6'h00, 1'b1);
        step(1);
        chk(alarm_current, 1'b1);
        chk(loop_code, LOOP_ALARM_HI);
        @(posedge clock);
        alarm_upscale_pin <= 1'b0;
        step(4);
        chk(loop_code, LOOP_ALARM_LO);
        @(posedge clock);
        fail_status_clr <= 1'b1;
        @(posedge clock);
        fail_detect <= 1'b0;
        #1;
        chk(fail_status, 1'b1);
        @(posedge clock);
        fail_status_clr <= 1'b0;
        #1;
        chk(fail_status, 1'b0);
        chk(alarm_current, 1'b0);
        chk(loop_code, 16'h5678);
    endtask

    task automatic t_cmd;
        wr(6'h09, 1'b1);
        u_host.send_cmd(6'h09);
        #1;
        chk(cmd_accept, 1'b1);
        u_host.send_cmd(6'h08);
        #1;
        chk(cmd_accept, 1'b0);
    endtask

    initial begin
        repeat (3) @(posedge clock);
        chk(poll_addr, 6'h00);
        chk(loop_code, LOOP_4MA_CODE);
        rst <= 1'b0;
        t_p2p();
        t_range();
        t_multi();
        t_cmd();
        close_out();
    end

    initial begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        close_out();
    end
endmodule
`default_nettype wire
